// ==== verilog/dbs_defs.svh ====
`ifndef DBS_DEFS_SVH
`define DBS_DEFS_SVH
`define DBS_NUM_BANKS 4
`define DBS_BANK_W 2
`define DBS_ROW_W 13
`define DBS_AP_BIT 10
`define DBS_CLK_PERIOD_PS 8000
`define DBS_PRECHARGE_PERIOD_PS 20000
`define DBS_ACT_TO_ACCESS_PS 20000
`define DBS_REFRESH_CYCLE_PS 75000
`define DBS_MODE_SET_CYCLES 2
`define DBS_SR_EXIT_PS 80000
`define DBS_SR_EXIT_READ_CYCLES 200
`define DBS_BURST_LEN 4
`define DBS_CNT_W 8
`endif

// ==== verilog/dbs_pkg.sv ====
package dbs_pkg;
  typedef enum logic [3:0] {
    DBS_CMD_DESEL, DBS_CMD_NOP, DBS_CMD_ACT, DBS_CMD_RD, DBS_CMD_WR,
    DBS_CMD_PRE, DBS_CMD_BST, DBS_CMD_REF, DBS_CMD_MRS
  } dbs_cmd_e;
  typedef enum logic [5:0] {
    DBS_B_IDLE = 6'h01, DBS_B_ACTIVATING = 6'h02, DBS_B_ACTIVE = 6'h04,
    DBS_B_READ = 6'h08, DBS_B_WRITE = 6'h10, DBS_B_PRECHARGING = 6'h20
  } dbs_bank_e;
  typedef enum logic [4:0] {
    DBS_P_RUN = 5'h01, DBS_P_PRE_PD = 5'h02, DBS_P_ACT_PD = 5'h04,
    DBS_P_SELF_REF = 5'h08, DBS_P_SR_EXIT = 5'h10
  } dbs_pwr_e;
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [1:0] bank;
    logic [12:0] addr;
  } dbs_cmd_s;
  typedef struct packed {
    logic inBufEn;
    logic outBufEn;
    logic dllRun;
    logic cmdsLegal;
    logic readsAllowed;
  } dbs_stat_s;
endpackage

// ==== verilog/dbs_bank_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_bank_ctrl #(
  parameter int NUM_BANKS = `DBS_NUM_BANKS,
  parameter int BURST_LEN = `DBS_BURST_LEN
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEnPin,
  input wire dbs_pkg::dbs_cmd_s cmdIn,
  input wire logic dllEnable,
  output logic [NUM_BANKS*6-1:0] bankStates,
  output dbs_pkg::dbs_pwr_e pwrState,
  output dbs_pkg::dbs_stat_s status
);
  import dbs_pkg::*;

  localparam int CW = `DBS_CNT_W;
  localparam logic [CW-1:0] PRE_CYC = CW'((`DBS_PRECHARGE_PERIOD_PS + `DBS_CLK_PERIOD_PS - 1) / `DBS_CLK_PERIOD_PS);
  localparam logic [CW-1:0] ACT_CYC = CW'((`DBS_ACT_TO_ACCESS_PS + `DBS_CLK_PERIOD_PS - 1) / `DBS_CLK_PERIOD_PS);
  localparam logic [CW-1:0] REF_CYC = CW'((`DBS_REFRESH_CYCLE_PS + `DBS_CLK_PERIOD_PS - 1) / `DBS_CLK_PERIOD_PS);
  localparam logic [CW-1:0] MRS_CYC = CW'(`DBS_MODE_SET_CYCLES);
  localparam logic [CW-1:0] SRX_CYC = CW'((`DBS_SR_EXIT_PS + `DBS_CLK_PERIOD_PS - 1) / `DBS_CLK_PERIOD_PS);
  localparam logic [CW-1:0] SRXR_CYC = CW'(`DBS_SR_EXIT_READ_CYCLES);
  localparam logic [CW-1:0] BURST_CYC = CW'(BURST_LEN / 2);

  ////////////////////////////////////////////////////////////
  function automatic dbs_cmd_e decode(input dbs_cmd_s c);
    if (c.csN) begin
      return DBS_CMD_DESEL;
    end
    case ({c.rasN, c.casN, c.weN})
      3'h7: return DBS_CMD_NOP;
      3'h3: return DBS_CMD_ACT;
      3'h5: return DBS_CMD_RD;
      3'h4: return DBS_CMD_WR;
      3'h2: return DBS_CMD_PRE;
      3'h6: return DBS_CMD_BST;
      3'h1: return DBS_CMD_REF;
      default: return DBS_CMD_MRS;
    endcase
  endfunction

  function automatic logic isNop(input dbs_cmd_e c);
    return (c == DBS_CMD_NOP) || (c == DBS_CMD_DESEL);
  endfunction

  ////////////////////////////////////////////////////////////
  // clock enable sampled at the pins: three stages, change taken when 2 and 3 agree; command registered once
  logic [2:0] ckeSync_r;
  logic ckeCur_r, ckePrev_r;
  dbs_cmd_s cmd_r;
  logic [2:0] ckeSync_nxt;
  logic ckeCur_nxt;

  always_comb begin
    ckeSync_nxt = {ckeSync_r[1:0], clkEnPin};
    ckeCur_nxt = ckeCur_r;
    if (ckeSync_r[1] == ckeSync_r[2]) begin
      ckeCur_nxt = ckeSync_r[2];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ckeSync_r <= 3'h0;
      ckeCur_r <= 1'b0;
      ckePrev_r <= 1'b0;
      cmd_r <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, bank: 2'h0, addr: 13'h0};
    end else begin
      ckeSync_r <= ckeSync_nxt;
      ckeCur_r <= ckeCur_nxt;
      ckePrev_r <= ckeCur_r;
      cmd_r <= cmdIn;
    end
  end

  dbs_cmd_e cmd;
  logic allBanks;
  assign cmd = decode(cmd_r);
  assign allBanks = cmd_r.addr[`DBS_AP_BIT];

  ////////////////////////////////////////////////////////////
  // bank state machines
  dbs_bank_e bank_r [NUM_BANKS];
  dbs_bank_e bank_nxt [NUM_BANKS];
  logic [CW-1:0] bankCnt_r [NUM_BANKS];
  logic [CW-1:0] bankCnt_nxt [NUM_BANKS];
  logic autoPre_r [NUM_BANKS];
  logic autoPre_nxt [NUM_BANKS];
  logic [1:0] lastRdBank_r, lastRdBank_nxt;
  logic lastRdValid_r, lastRdValid_nxt;
  dbs_pwr_e pwr_r, pwr_nxt;
  logic [CW-1:0] pwrCnt_r, pwrCnt_nxt;
  logic [CW-1:0] blockCnt_r, blockCnt_nxt;
  logic [CW-1:0] readHold_r, readHold_nxt;
  logic allIdle, anyBurst, cmdLive;

  always_comb begin
    allIdle = 1'b1;
    anyBurst = 1'b0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (bank_r[b] != DBS_B_IDLE) begin
        allIdle = 1'b0;
      end
      if (bank_r[b] inside {DBS_B_READ, DBS_B_WRITE, DBS_B_ACTIVATING, DBS_B_PRECHARGING} || autoPre_r[b]) begin
        anyBurst = 1'b1;
      end
    end
  end

  // bank rules only with enable high at both edges and self-refresh exit done
  assign cmdLive = ckePrev_r && ckeCur_r && (pwr_r == DBS_P_RUN) && (blockCnt_r == '0);

  always_comb begin
    lastRdBank_nxt = lastRdBank_r;
    lastRdValid_nxt = lastRdValid_r;
    for (int b = 0; b < NUM_BANKS; b++) begin
      logic hit;
      hit = allBanks || (cmd_r.bank == 2'(b));
      bank_nxt[b] = bank_r[b];
      autoPre_nxt[b] = autoPre_r[b];
      bankCnt_nxt[b] = (bankCnt_r[b] != '0) ? bankCnt_r[b] - 1'b1 : '0;
      // timed states expire
      case (bank_r[b])
        DBS_B_PRECHARGING: if (bankCnt_r[b] <= 1) begin
          bank_nxt[b] = DBS_B_IDLE;
          autoPre_nxt[b] = 1'b0;
        end
        DBS_B_ACTIVATING: if (bankCnt_r[b] <= 1) begin
          bank_nxt[b] = DBS_B_ACTIVE;
        end
        DBS_B_READ, DBS_B_WRITE: if (bankCnt_r[b] <= 1) begin
          // auto precharge starts when the burst completes
          bank_nxt[b] = autoPre_r[b] ? DBS_B_PRECHARGING : DBS_B_ACTIVE;
          bankCnt_nxt[b] = PRE_CYC;
        end
        default: ;
      endcase
      if (cmdLive && cmd_r.bank == 2'(b)) begin
        case (bank_r[b])
          DBS_B_IDLE: if (cmd == DBS_CMD_ACT) begin
            bank_nxt[b] = DBS_B_ACTIVATING;
            bankCnt_nxt[b] = ACT_CYC;
          end
          DBS_B_ACTIVE, DBS_B_READ, DBS_B_WRITE: if (!autoPre_r[b]) begin
            if (cmd == DBS_CMD_RD || cmd == DBS_CMD_WR) begin
              // a new access restarts the burst; write truncated by read
              bank_nxt[b] = (cmd == DBS_CMD_RD) ? DBS_B_READ : DBS_B_WRITE;
              bankCnt_nxt[b] = BURST_CYC;
              autoPre_nxt[b] = cmd_r.addr[`DBS_AP_BIT];
            end
          end
          default: ;
        endcase
        if (cmd == DBS_CMD_RD && bank_r[b] != DBS_B_IDLE && !autoPre_r[b]) begin
          lastRdBank_nxt = 2'(b);
          lastRdValid_nxt = 1'b1;
        end
      end
      // precharge, single or all banks
      if (cmdLive && cmd == DBS_CMD_PRE && hit && !autoPre_r[b] &&
          (bank_r[b] == DBS_B_ACTIVE || bank_r[b] == DBS_B_READ || bank_r[b] == DBS_B_WRITE)) begin
        bank_nxt[b] = DBS_B_PRECHARGING;
        bankCnt_nxt[b] = PRE_CYC;
      end
      // terminate hits whichever bank last started a read
      if (cmdLive && cmd == DBS_CMD_BST && lastRdValid_r && lastRdBank_r == 2'(b) &&
          bank_r[b] == DBS_B_READ && !autoPre_r[b]) begin
        bank_nxt[b] = DBS_B_ACTIVE;
        bankCnt_nxt[b] = '0;
        lastRdValid_nxt = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // power and clock-enable handling
  always_comb begin
    pwr_nxt = pwr_r;
    pwrCnt_nxt = (pwrCnt_r != '0) ? pwrCnt_r - 1'b1 : '0;
    blockCnt_nxt = (blockCnt_r != '0) ? blockCnt_r - 1'b1 : '0;
    readHold_nxt = (readHold_r != '0) ? readHold_r - 1'b1 : '0;
    case (pwr_r)
      DBS_P_RUN: begin
        if (ckePrev_r && !ckeCur_r) begin
          if (cmd == DBS_CMD_REF && allIdle) begin
            pwr_nxt = DBS_P_SELF_REF;
          end else if (isNop(cmd) && !anyBurst) begin
            pwr_nxt = allIdle ? DBS_P_PRE_PD : DBS_P_ACT_PD;
          end
        end else if (cmdLive && allIdle) begin
          // refresh and mode set hold off every command except power-down and self-refresh entry
          if (cmd == DBS_CMD_REF) begin
            blockCnt_nxt = REF_CYC;
          end else if (cmd == DBS_CMD_MRS) begin
            blockCnt_nxt = MRS_CYC;
          end
        end
      end
      DBS_P_PRE_PD, DBS_P_ACT_PD: begin
        // low-low holds; low-high with nop exits
        if (!ckePrev_r && ckeCur_r && isNop(cmd)) begin
          pwr_nxt = DBS_P_RUN;
        end
      end
      DBS_P_SELF_REF: begin
        if (!ckePrev_r && ckeCur_r && isNop(cmd)) begin
          pwr_nxt = DBS_P_SR_EXIT;
          pwrCnt_nxt = SRX_CYC;
          readHold_nxt = SRXR_CYC;
        end
      end
      DBS_P_SR_EXIT: begin
        if (pwrCnt_r <= 1) begin
          pwr_nxt = DBS_P_RUN;
        end
      end
      default: pwr_nxt = DBS_P_RUN;
    endcase
    // relock time counts from the DLL's return, or from the self-refresh exit if that is later
    if (!dllEnable) begin
      readHold_nxt = SRXR_CYC;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_r[b] <= DBS_B_IDLE;
        bankCnt_r[b] <= '0;
        autoPre_r[b] <= 1'b0;
      end
      lastRdBank_r <= 2'h0;
      lastRdValid_r <= 1'b0;
      pwr_r <= DBS_P_RUN;
      pwrCnt_r <= '0;
      blockCnt_r <= '0;
      readHold_r <= '0;
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_r[b] <= bank_nxt[b];
        bankCnt_r[b] <= bankCnt_nxt[b];
        autoPre_r[b] <= autoPre_nxt[b];
      end
      lastRdBank_r <= lastRdBank_nxt;
      lastRdValid_r <= lastRdValid_nxt;
      pwr_r <= pwr_nxt;
      pwrCnt_r <= pwrCnt_nxt;
      blockCnt_r <= blockCnt_nxt;
      readHold_r <= readHold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // buffers off in any power-down, clock and enable inputs stay live
  logic bufOn;
  assign bufOn = (pwr_r == DBS_P_RUN) || (pwr_r == DBS_P_SR_EXIT);

  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      bankStates[b*6 +: 6] = bank_r[b];
    end
  end

  assign pwrState = pwr_r;
  assign status = '{inBufEn: bufOn, outBufEn: bufOn, dllRun: dllEnable,
                    cmdsLegal: cmdLive, readsAllowed: cmdLive && (readHold_r == '0)};
endmodule
`default_nettype wire

// ==== testbench/dbs_bank_ctrl_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module dbs_bank_ctrl_checker #(
  parameter int NUM_BANKS = 4,
  parameter int BURST_LEN = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEnPin,
  input wire dbs_pkg::dbs_cmd_s cmdIn,
  input wire logic dllEnable,
  input wire logic [NUM_BANKS*6-1:0] bankStates,
  input wire dbs_pkg::dbs_pwr_e pwrState,
  input wire dbs_pkg::dbs_stat_s status
);
  import dbs_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [5:0] b0;
  logic pd;
  assign b0 = bankStates[5:0];
  assign pd = pwrState inside {DBS_P_PRE_PD, DBS_P_ACT_PD, DBS_P_SELF_REF};
  // cycles since self-refresh was left, saturating
  logic [8:0] srxAge;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      srxAge <= 9'h1ff;
    end else if (pwrState == DBS_P_SELF_REF) begin
      srxAge <= 9'h000;
    end else if (srxAge != 9'h1ff) begin
      srxAge <= srxAge + 9'h001;
    end
  end
  ////////////////////////////////////////
  sequence s_open;
    (b0 == DBS_B_ACTIVATING) [*3] ##1 b0 == DBS_B_ACTIVE;
  endsequence
  sequence s_close;
    (b0 == DBS_B_PRECHARGING) [*3] ##1 b0 == DBS_B_IDLE;
  endsequence
  a_act_time: assert property (b0 == DBS_B_ACTIVATING && $past(b0) != DBS_B_ACTIVATING |-> s_open)
    else $error("bad activate timing");
  a_pre_time: assert property (b0 == DBS_B_PRECHARGING && $past(b0) != DBS_B_PRECHARGING |-> s_close)
    else $error("bad precharge timing");
  a_read_src: assert property (b0 == DBS_B_READ && $past(b0) != DBS_B_READ |->
    $past(b0) inside {DBS_B_ACTIVE, DBS_B_WRITE}) else $error("read from closed bank");
  a_pd_bufs: assert property (pd |-> !status.inBufEn && !status.outBufEn)
    else $error("buffers on in power-down");
  a_pd_legal: assert property (pwrState != DBS_P_RUN |-> !status.cmdsLegal)
    else $error("commands legal outside run");
  a_pre_pd_idle: assert property (pwrState == DBS_P_PRE_PD |-> bankStates == {NUM_BANKS{6'h01}})
    else $error("precharge power-down with open bank");
  a_act_pd_open: assert property (pwrState == DBS_P_ACT_PD |-> bankStates != {NUM_BANKS{6'h01}})
    else $error("active power-down with all idle");
  a_sr_noread: assert property (pwrState == DBS_P_SR_EXIT |-> !status.readsAllowed)
    else $error("reads allowed in self-refresh exit");
  a_sr_relock: assert property (status.readsAllowed |-> srxAge >= 9'h0c8)
    else $error("read allowed before DLL relock");
endmodule
bind dbs_bank_ctrl dbs_bank_ctrl_checker #(.NUM_BANKS(NUM_BANKS), .BURST_LEN(BURST_LEN)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .clkEnPin(clkEnPin), .cmdIn(cmdIn), .dllEnable(dllEnable),
  .bankStates(bankStates), .pwrState(pwrState), .status(status));
`default_nettype wire

// ==== testbench/dbs_ctl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dbs_ctl_model (
  input wire logic ref_clk,
  output dbs_pkg::dbs_cmd_s cmdIn,
  output logic clkEnPin,
  output logic dllEnable
);
  import dbs_pkg::*;
  // strobes csN,rasN,casN,weN in enum order
  localparam logic [3:0] ENC [9] = '{4'h8, 4'h7, 4'h3, 4'h5, 4'h4, 4'h2, 4'h6, 4'h1, 4'h0};
  initial begin
    cmdIn = {4'h7, 15'h0};
    clkEnPin = 1'b1;
    dllEnable = 1'b1;
  end
  ////////////////////////////////////////
  // callers order commands by bank state
  task automatic send(input dbs_cmd_e c, input logic [1:0] b, input logic [12:0] a);
    @(posedge ref_clk);
    if (c inside {DBS_CMD_NOP, DBS_CMD_DESEL}) begin
      // don't-care lines toggle so no stale value can be relied on
      cmdIn <= {ENC[c], ~cmdIn.bank, ~cmdIn.addr};
    end else begin
      cmdIn <= {ENC[c], b, a};
    end
  endtask
  task automatic pins(input logic cke, input logic dll);
    @(posedge ref_clk);
    clkEnPin <= cke;
    dllEnable <= dll;
  endtask
endmodule
`default_nettype wire

// ==== testbench/dbs_bank_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module dbs_bank_ctrl_tb;
  import dbs_pkg::*;
  logic ref_clk;
  logic rst;
  logic clkEnPin;
  logic dllEnable;
  dbs_cmd_s cmdIn;
  logic [23:0] bankStates;
  dbs_pwr_e pwrState;
  dbs_stat_s status;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  dbs_ctl_model ctl (.ref_clk(ref_clk), .cmdIn(cmdIn), .clkEnPin(clkEnPin), .dllEnable(dllEnable));
  dbs_bank_ctrl dut (.ref_clk(ref_clk), .rst(rst), .clkEnPin(clkEnPin), .cmdIn(cmdIn),
    .dllEnable(dllEnable), .bankStates(bankStates), .pwrState(pwrState), .status(status));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task automatic results;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // +1ns lets the edge's register updates land before sampling
  task automatic at(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic bk(input int b, input dbs_bank_e e);
    chk(32'(bankStates[b*6+:6]), 32'(e));
  endtask
  task automatic cmd(input dbs_cmd_e c, input int b, input int a);
    ctl.send(c, 2'(b), 13'(a));
  endtask
  task automatic go(input dbs_cmd_e c, input int b, input int a, input int n);
    cmd(c, b, a);
    cmd(DBS_CMD_NOP, 0, 0);
    at(n);
  endtask
  task automatic waitPwr(input dbs_pwr_e e);
    for (int i = 0; i < 40 && pwrState !== e; i++) at(1);
    chk(32'(pwrState), 32'(e));
  endtask
  ////////////////////////////////////////
  task automatic t_act_pre;
    go(DBS_CMD_ACT, 0, 0, 1);
    bk(0, DBS_B_ACTIVATING);
    at(2);
    bk(0, DBS_B_ACTIVATING);
    at(1);
    bk(0, DBS_B_ACTIVE);
    go(DBS_CMD_PRE, 0, 0, 3);
    bk(0, DBS_B_PRECHARGING);
    at(1);
    bk(0, DBS_B_IDLE);
    cmd(DBS_CMD_ACT, 0, 0);
    go(DBS_CMD_ACT, 2, 0, 5);
    go(DBS_CMD_PRE, 3, 'h400, 1);
    bk(0, DBS_B_PRECHARGING);
    bk(2, DBS_B_PRECHARGING);
    at(3);
  endtask
  task automatic t_burst;
    go(DBS_CMD_ACT, 0, 0, 5);
    cmd(DBS_CMD_RD, 0, 0);
    go(DBS_CMD_BST, 2, 0, 0);
    bk(0, DBS_B_READ);
    at(1);
    bk(0, DBS_B_ACTIVE);
    cmd(DBS_CMD_RD, 0, 0);
    go(DBS_CMD_RD, 0, 0, 2);
    bk(0, DBS_B_READ);
    cmd(DBS_CMD_RD, 0, 0);
    go(DBS_CMD_PRE, 0, 0, 1);
    bk(0, DBS_B_PRECHARGING);
    at(2);
    go(DBS_CMD_ACT, 0, 0, 5);
    cmd(DBS_CMD_WR, 0, 0);
    go(DBS_CMD_RD, 0, 0, 0);
    bk(0, DBS_B_WRITE);
    at(1);
    bk(0, DBS_B_READ);
    at(3);
    go(DBS_CMD_RD, 0, 13'h400, 3);
    bk(0, DBS_B_PRECHARGING);
    at(3);
    bk(0, DBS_B_IDLE);
  endtask
  task automatic t_power;
    ctl.pins(1'b0, 1'b0);
    waitPwr(DBS_P_PRE_PD);
    chk(32'(status.inBufEn), 0);
    chk(32'(status.cmdsLegal), 0);
    chk(32'(status.dllRun), 0);
    go(DBS_CMD_ACT, 0, 0, 2);
    ctl.pins(1'b1, 1'b1);
    waitPwr(DBS_P_RUN);
    bk(0, DBS_B_IDLE);
    chk(32'(status.inBufEn), 1);
    chk(32'(status.readsAllowed), 0);
    at(205);
    chk(32'(status.readsAllowed), 1);
    go(DBS_CMD_ACT, 1, 0, 5);
    ctl.pins(1'b0, 1'b1);
    waitPwr(DBS_P_ACT_PD);
    chk(32'(status.outBufEn), 0);
    ctl.pins(1'b1, 1'b1);
    waitPwr(DBS_P_RUN);
    bk(1, DBS_B_ACTIVE);
    chk(32'(status.readsAllowed), 1);
    go(DBS_CMD_PRE, 1, 0, 5);
  endtask
  task automatic t_selfref;
    go(DBS_CMD_MRS, 0, 0, 1);
    chk(32'(status.cmdsLegal), 0);
    cmd(DBS_CMD_DESEL, 0, 0);
    at(4);
    chk(32'(status.cmdsLegal), 1);
    ctl.pins(1'b0, 1'b1);
    cmd(DBS_CMD_REF, 0, 0);
    waitPwr(DBS_P_SELF_REF);
    cmd(DBS_CMD_NOP, 0, 0);
    ctl.pins(1'b1, 1'b1);
    waitPwr(DBS_P_SR_EXIT);
    waitPwr(DBS_P_RUN);
    chk(32'(status.readsAllowed), 0);
    at(205);
    chk(32'(status.readsAllowed), 1);
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    at(10);
    t_act_pre();
    t_burst();
    t_power();
    t_selfref();
    results();
  end
  // run needs about 570 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
endmodule
`default_nettype wire
